// [nvac_pkg.sv]
// Package with register map, field layout and timing of the nv access block
`default_nettype none
package nvac_pkg;
	// Register indices on the plain register port
	localparam int NVAC_AW = 4;
	localparam logic [3:0] NVAC_IDX_CONTROL = 4'h0;
	localparam logic [3:0] NVAC_IDX_UNLOCK = 4'h1;
	localparam logic [3:0] NVAC_IDX_DATA_LOW = 4'h2;
	localparam logic [3:0] NVAC_IDX_DATA_HIGH = 4'h3;
	localparam logic [3:0] NVAC_IDX_ADDR_LOW = 4'h4;
	localparam logic [3:0] NVAC_IDX_ADDR_HIGH = 4'h5;
	localparam logic [3:0] NVAC_IDX_INT_STATUS = 4'h6;
	localparam logic [3:0] NVAC_IDX_INT_MASK = 4'h7;
	// nv_control field positions
	localparam int NVAC_BIT_RD = 0;
	localparam int NVAC_BIT_WR = 1;
	localparam int NVAC_BIT_WRITE_ALLOW = 2;
	localparam int NVAC_BIT_ABORT = 3;
	localparam int NVAC_BIT_SPACE = 7;
	// Interrupt status and mask positions
	localparam int NVAC_IRQ_DONE = 0;
	localparam int NVAC_IRQ_REFUSED = 1;
	// Reset values and erased EEPROM byte value
	localparam logic [1:0] NVAC_IRQ_RST = 2'h0;
	localparam logic [7:0] NVAC_BYTE_RST = 8'h00;
	localparam logic [7:0] NVAC_EE_ERASED = 8'hFF;
	// Unlock sequence
	localparam logic [7:0] NVAC_KEY1 = 8'h55;
	localparam logic [7:0] NVAC_KEY2 = 8'hAA;
	localparam logic [1:0] NVAC_UNL_LOCKED = 2'h0;
	localparam logic [1:0] NVAC_UNL_HALF = 2'h1;
	localparam logic [1:0] NVAC_UNL_OPEN = 2'h2;
	// Program memory self-write protection limits (word addresses)
	localparam logic [14:0] NVAC_WP_QUARTER = 15'h0800;
	localparam logic [14:0] NVAC_WP_HALF = 15'h1000;
	localparam logic [14:0] NVAC_PM_WORDS = 15'h2000;
	// Write timing
	localparam int unsigned NVAC_WRITE_TIME_US = 2000;
	localparam int unsigned NVAC_CLK_MHZ = 250;
	localparam int unsigned NVAC_WRITE_CYCLES =
		NVAC_WRITE_TIME_US * NVAC_CLK_MHZ;
	localparam int NVAC_TMR_W = 20;
	// Sequencer states
	typedef enum logic [2:0] {
		NVAC_ST_IDLE = 3'b001,
		NVAC_ST_READ = 3'b010,
		NVAC_ST_WRITE = 3'b100
	} nvac_state_t;
endpackage
`default_nettype wire

// [nvac_ee_if.sv]
// Interface between the sequencer and the data EEPROM array
`default_nettype none
interface nvac_ee_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	modport ctl (output req, we, addr, wdata, input ack, rdata);
	modport mem (input req, we, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// [nvac_ee_array.sv]
// Data EEPROM array, 256 bytes, erase before program
`default_nettype none
module nvac_ee_array
	import nvac_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Sequencer side
	nvac_ee_if.mem ee
);
	logic [7:0] mem_q [256];
	logic prog_q;
	logic ack_q;
	logic [7:0] rdata_q;

	assign ee.ack = ack_q;
	assign ee.rdata = rdata_q;

	// Erase on the first cycle, program on the second
	always_ff @(posedge clk_sys)
	begin
		if (prog_q)
			mem_q[ee.addr] <= ee.wdata;
		else if (ee.req && ee.we && !ack_q)
			mem_q[ee.addr] <= NVAC_EE_ERASED;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			prog_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= NVAC_BYTE_RST;
		end
		else
		begin
			ack_q <= 1'b0;
			if (prog_q)
			begin
				prog_q <= 1'b0;
				ack_q <= 1'b1;
			end
			else if (ee.req && ee.we && !ack_q)
				prog_q <= 1'b1;
			else if (ee.req && !ee.we && !ack_q)
			begin
				rdata_q <= mem_q[ee.addr];
				ack_q <= 1'b1;
			end
		end
	end

	property p_erase_then_prog;
		@(posedge clk_sys) disable iff (rst)
		(ee.req && ee.we && !ack_q && !prog_q) |=>
			mem_q[$past(ee.addr)] == NVAC_EE_ERASED ##1
			ack_q && mem_q[$past(ee.addr, 2)] == $past(ee.wdata, 2);
	endproperty
	a_erase_then_prog: assert property (p_erase_then_prog)
		else $error("byte write did not erase then program");
endmodule // nvac_ee_array
`default_nettype wire

// [nvac_wtimer.sv]
// On-chip write duration timer
`default_nettype none
module nvac_wtimer
	import nvac_pkg::*;
#(
	parameter int unsigned CYCLES = NVAC_WRITE_CYCLES
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic start,
	output logic busy,
	output logic done
);
	logic [NVAC_TMR_W-1:0] cnt_q;
	logic [NVAC_TMR_W-1:0] hlp_q;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cnt_q <= '0;
		else if (start)
			cnt_q <= NVAC_TMR_W'(CYCLES);
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign busy = (cnt_q != '0);
	assign done = (cnt_q == NVAC_TMR_W'(1));

	// Cycles since the last start
	always_ff @(posedge clk_sys)
	begin
		if (rst || start)
			hlp_q <= NVAC_TMR_W'(1);
		else
			hlp_q <= hlp_q + 1'b1;
	end

	property p_timer_len;
		@(posedge clk_sys) disable iff (rst)
		done |-> hlp_q == NVAC_TMR_W'(CYCLES);
	endproperty
	a_timer_len: assert property (p_timer_len)
		else $error("write time differs from the timer count");
endmodule // nvac_wtimer
`default_nettype wire

// [nvac_top.sv]
// Data EEPROM and program flash access controller
//
// Overview of operation
// - Arrays reached only through six access registers, never directly.
// - Reads and writes run in normal operation, no special mode.
// - EEPROM uses data_low byte and addr_low over 256 locations.
// - Program memory uses 14-bit data pair and 15-bit address pair.
// - EEPROM byte write erases the location then programs it.
// - Write duration comes from an internal timer and charge pump.
// - Protection field blocks self-writes; program reads always allowed.
// - Code protection shuts out the external programmer, not the core.
// - space_select clear picks EEPROM, set picks program; device reset clears.
// - Read and write triggers set by software, cleared by hardware.
// - Writes need write_allow; reset during write sets abort flag.
// - Write completion sets write_done_flag; software clears it.
`default_nettype none
module nvac_top
	import nvac_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = NVAC_WRITE_CYCLES
)
(
	// Clock and resets
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pwr_on_rst,
	// Register port
	input wire logic [NVAC_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// Configuration pins
	input wire logic [1:0] cfg_self_write_protect,
	input wire logic cfg_code_protect,
	// Program flash array
	output logic pm_req,
	output logic pm_we,
	output logic [14:0] pm_addr,
	output logic [13:0] pm_wdata,
	input wire logic pm_ack,
	input wire logic [13:0] pm_rdata,
	// Status outputs
	output logic charge_pump_en,
	output logic ext_prog_allow,
	output logic irq
);
	nvac_state_t state_q;
	logic [2:0] cfg_s1_q;
	logic [2:0] cfg_s2_q;
	logic space_q;
	logic allow_q;
	logic abort_q;
	logic rd_q;
	logic wr_q;
	logic [1:0] unlock_q;
	logic [7:0] data_lo_q;
	logic [5:0] data_hi_q;
	logic [7:0] addr_lo_q;
	logic [6:0] addr_hi_q;
	logic [1:0] status_q;
	logic [1:0] status_d;
	logic [1:0] mask_q;
	logic [7:0] rdata_q;
	logic ee_req_q;
	logic pm_req_q;
	logic we_q;
	logic [14:0] word_addr;
	logic [1:0] wp;
	logic idle;
	logic arr_ack;
	logic prot_hit;
	logic wr_blocked;
	logic rd_start;
	logic wr_start;
	logic wr_refused;
	logic rd_done;
	logic wr_done;
	logic tmr_done;
	logic wr_arm;
	logic wr_ctl;
	logic wr_unl;

	nvac_ee_if ee ();

	nvac_ee_array u_ee (
		.clk_sys(clk_sys),
		.rst(rst),
		.ee(ee.mem)
	);

	nvac_wtimer #(.CYCLES(WRITE_CYCLES)) u_tmr (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(wr_start),
		.busy(),
		.done(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration pin synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cfg_s1_q <= 3'h0;
			cfg_s2_q <= 3'h0;
		end
		else
		begin
			cfg_s1_q <= {cfg_code_protect, cfg_self_write_protect};
			cfg_s2_q <= cfg_s1_q;
		end
	end

	assign wp = cfg_s2_q[1:0];
	assign ext_prog_allow = !cfg_s2_q[2];

	////////////////////////////////////////////////////////////////////////
	// Decode and sequencing terms
	assign wr_ctl = reg_we && (reg_addr == NVAC_IDX_CONTROL);
	assign wr_unl = reg_we && (reg_addr == NVAC_IDX_UNLOCK);
	assign idle = (state_q == NVAC_ST_IDLE) && !rd_q && !wr_q;
	assign word_addr = {addr_hi_q, addr_lo_q};

	// Protected program region by the two-bit field
	always_comb
	begin
		unique case (wp)
			2'h3: prot_hit = 1'b0;
			2'h2: prot_hit = word_addr < NVAC_WP_QUARTER;
			2'h1: prot_hit = word_addr < NVAC_WP_HALF;
			2'h0: prot_hit = word_addr < NVAC_PM_WORDS;
		endcase
	end

	assign wr_blocked = !allow_q || (space_q && prot_hit);
	assign arr_ack = space_q ? pm_ack : ee.ack;
	// Reads are never gated by protection
	assign rd_start = (state_q == NVAC_ST_IDLE) && rd_q;
	assign wr_start = (state_q == NVAC_ST_IDLE) && !rd_q && wr_q
		&& !wr_blocked;
	assign wr_refused = (state_q == NVAC_ST_IDLE) && !rd_q && wr_q
		&& wr_blocked;
	assign rd_done = (state_q == NVAC_ST_READ) && arr_ack;
	assign wr_done = (state_q == NVAC_ST_WRITE) && tmr_done;
	assign wr_arm = wr_ctl && reg_wdata[NVAC_BIT_WR] && !wr_q
		&& reg_wdata[NVAC_BIT_WRITE_ALLOW]
		&& (unlock_q == NVAC_UNL_OPEN);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= NVAC_ST_IDLE;
			ee_req_q <= 1'b0;
			pm_req_q <= 1'b0;
			we_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				NVAC_ST_IDLE:
				begin
					if (rd_start || wr_start)
					begin
						state_q <= rd_start ? NVAC_ST_READ : NVAC_ST_WRITE;
						we_q <= !rd_start;
						pm_req_q <= space_q;
						ee_req_q <= !space_q;
					end
				end
				NVAC_ST_READ:
				begin
					if (arr_ack)
					begin
						state_q <= NVAC_ST_IDLE;
						ee_req_q <= 1'b0;
						pm_req_q <= 1'b0;
					end
				end
				NVAC_ST_WRITE:
				begin
					if (arr_ack)
					begin
						ee_req_q <= 1'b0;
						pm_req_q <= 1'b0;
					end
					if (tmr_done)
					begin
						state_q <= NVAC_ST_IDLE;
						we_q <= 1'b0;
					end
				end
				default:
				begin
					state_q <= NVAC_ST_IDLE;
					ee_req_q <= 1'b0;
					pm_req_q <= 1'b0;
					we_q <= 1'b0;
				end
			endcase
		end
	end

	assign charge_pump_en = (state_q == NVAC_ST_WRITE);
	assign pm_req = pm_req_q;
	assign pm_we = we_q;
	assign pm_addr = word_addr;
	assign pm_wdata = {data_hi_q, data_lo_q};
	assign ee.req = ee_req_q;
	assign ee.we = we_q;
	assign ee.addr = addr_lo_q;
	assign ee.wdata = data_lo_q;

	////////////////////////////////////////////////////////////////////////
	// Control bits
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			space_q <= 1'b0;
			allow_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else
		begin
			if (wr_ctl && idle)
				space_q <= reg_wdata[NVAC_BIT_SPACE];
			if (wr_ctl)
				allow_q <= reg_wdata[NVAC_BIT_WRITE_ALLOW];
			// Software may only set the triggers
			if (rd_done)
				rd_q <= 1'b0;
			else if (wr_ctl && reg_wdata[NVAC_BIT_RD] && idle)
				rd_q <= 1'b1;
			if (wr_done || wr_refused)
				wr_q <= 1'b0;
			else if (wr_arm && idle)
				wr_q <= 1'b1;
		end
	end

	// Abort flag survives device reset
	always_ff @(posedge clk_sys)
	begin
		if (pwr_on_rst)
			abort_q <= 1'b0;
		else if (rst)
		begin
			if (state_q == NVAC_ST_WRITE)
				abort_q <= 1'b1;
		end
		else if (wr_ctl && !reg_wdata[NVAC_BIT_ABORT])
			abort_q <= 1'b0;
	end

	// Unlock pattern tracker, consumed by any control write
	always_ff @(posedge clk_sys)
	begin
		if (rst || wr_ctl)
			unlock_q <= NVAC_UNL_LOCKED;
		else if (wr_unl)
		begin
			if (reg_wdata == NVAC_KEY1)
				unlock_q <= NVAC_UNL_HALF;
			else if (unlock_q == NVAC_UNL_HALF && reg_wdata == NVAC_KEY2)
				unlock_q <= NVAC_UNL_OPEN;
			else
				unlock_q <= NVAC_UNL_LOCKED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data and address registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			data_lo_q <= NVAC_BYTE_RST;
			data_hi_q <= 6'h00;
			addr_lo_q <= NVAC_BYTE_RST;
			addr_hi_q <= 7'h00;
		end
		else if (rd_done)
		begin
			data_lo_q <= space_q ? pm_rdata[7:0] : ee.rdata;
			if (space_q)
				data_hi_q <= pm_rdata[13:8];
		end
		else if (reg_we && idle)
		begin
			if (reg_addr == NVAC_IDX_DATA_LOW)
				data_lo_q <= reg_wdata;
			if (reg_addr == NVAC_IDX_DATA_HIGH)
				data_hi_q <= reg_wdata[5:0];
			if (reg_addr == NVAC_IDX_ADDR_LOW)
				addr_lo_q <= reg_wdata;
			if (reg_addr == NVAC_IDX_ADDR_HIGH)
				addr_hi_q <= reg_wdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	always_comb
	begin
		status_d = status_q;
		if (reg_we && reg_addr == NVAC_IDX_INT_STATUS)
			status_d = status_q & ~reg_wdata[1:0];
		// Hardware set wins over a same-cycle clear
		status_d[NVAC_IRQ_DONE] = status_d[NVAC_IRQ_DONE] | wr_done;
		status_d[NVAC_IRQ_REFUSED] = status_d[NVAC_IRQ_REFUSED]
			| wr_refused;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			status_q <= NVAC_IRQ_RST;
			mask_q <= NVAC_IRQ_RST;
		end
		else
		begin
			status_q <= status_d;
			if (reg_we && reg_addr == NVAC_IDX_INT_MASK)
				mask_q <= reg_wdata[1:0];
		end
	end

	assign irq = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge clk_sys)
	begin
		if (rst || !reg_re)
			rdata_q <= NVAC_BYTE_RST;
		else
		begin
			unique case (reg_addr)
				NVAC_IDX_CONTROL:
				begin
					rdata_q <= NVAC_BYTE_RST;
					rdata_q[NVAC_BIT_RD] <= rd_q;
					rdata_q[NVAC_BIT_WR] <= wr_q;
					rdata_q[NVAC_BIT_WRITE_ALLOW] <= allow_q;
					rdata_q[NVAC_BIT_ABORT] <= abort_q;
					rdata_q[NVAC_BIT_SPACE] <= space_q;
				end
				NVAC_IDX_DATA_LOW: rdata_q <= data_lo_q;
				NVAC_IDX_DATA_HIGH: rdata_q <= {2'h0, data_hi_q};
				NVAC_IDX_ADDR_LOW: rdata_q <= addr_lo_q;
				NVAC_IDX_ADDR_HIGH: rdata_q <= {1'h0, addr_hi_q};
				NVAC_IDX_INT_STATUS: rdata_q <= {6'h00, status_q};
				NVAC_IDX_INT_MASK: rdata_q <= {6'h00, mask_q};
				default: rdata_q <= NVAC_BYTE_RST;
			endcase
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_unlock_read;
		reg_re && reg_addr == NVAC_IDX_UNLOCK;
	endsequence
	sequence s_start_pm;
		(state_q == NVAC_ST_IDLE) && (rd_start || wr_start) && space_q;
	endsequence

	property p_unlock_zero;
		s_unlock_read |=> reg_rdata == NVAC_BYTE_RST;
	endproperty
	a_unlock_zero: assert property (p_unlock_zero)
		else $error("unlock register read back nonzero");

	property p_pm_addr;
		s_start_pm |=> pm_req && !ee.req
			&& pm_addr == {$past(addr_hi_q), $past(addr_lo_q)};
	endproperty
	a_pm_addr: assert property (p_pm_addr)
		else $error("program access used wrong space or address");

	property p_ee_read;
		rd_done && !space_q |=> data_lo_q == $past(ee.rdata);
	endproperty
	a_ee_read: assert property (p_ee_read)
		else $error("EEPROM read byte not captured");

	property p_pump;
		wr_start |=> charge_pump_en [*8];
	endproperty
	a_pump: assert property (p_pump)
		else $error("charge pump not held during write");

	property p_read_free;
		rd_q && state_q == NVAC_ST_IDLE |=> state_q == NVAC_ST_READ;
	endproperty
	a_read_free: assert property (p_read_free)
		else $error("read was not started");

	property p_wr_hold;
		wr_q && !wr_done && !wr_refused |=> wr_q;
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write trigger dropped early");

	property p_wr_allow;
		wr_start |-> allow_q && (!space_q || wp == 2'h3
			|| (wp == 2'h2 && word_addr >= NVAC_WP_QUARTER)
			|| (wp == 2'h1 && word_addr >= NVAC_WP_HALF)
			|| (wp == 2'h0 && word_addr >= NVAC_PM_WORDS));
	endproperty
	a_wr_allow: assert property (p_wr_allow)
		else $error("write started without allow or in protected area");

	property p_done_flag;
		wr_done |=> status_q[NVAC_IRQ_DONE] && !wr_q;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("write completion not flagged");

	property p_locked;
		wr_ctl && unlock_q != NVAC_UNL_OPEN && !wr_q |=> !wr_q;
	endproperty
	a_locked: assert property (p_locked)
		else $error("write trigger accepted without unlock");

	property p_space_rst;
		@(posedge clk_sys) disable iff (1'b0)
		$fell(rst) |-> !space_q && !allow_q;
	endproperty
	a_space_rst: assert property (p_space_rst)
		else $error("space select or write allow not cleared by reset");

	property p_prog_lock;
		@(posedge clk_sys) disable iff (rst)
		$past(cfg_code_protect, 3) && $past(cfg_code_protect, 2)
			&& !$past(rst) && !$past(rst, 2) |-> !ext_prog_allow;
	endproperty
	a_prog_lock: assert property (p_prog_lock)
		else $error("programmer allowed under code protection");
endmodule // nvac_top
`default_nettype wire

// [nvac_pm_model.sv]
// Behavioural program flash array that answers the access controller
`default_nettype none
module nvac_pm_model
	import nvac_pkg::*;
(
	// Clock, reset and answer delay
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] delay,
	// Flash request side
	input wire logic pm_req,
	input wire logic pm_we,
	input wire logic [14:0] pm_addr,
	input wire logic [13:0] pm_wdata,
	output logic pm_ack,
	output logic [13:0] pm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] mem [0:32767];
	logic [3:0] wait_q;
	logic served_q;
	initial
	begin
		pm_ack = 1'b0;
		pm_rdata = 14'h1555;
		foreach (mem[i])
			mem[i] = 14'h3FFF;
	end
	// One ack per request; read data garbles outside the ack cycle
	always @(posedge clk_sys)
	begin
		pm_ack <= 1'b0;
		pm_rdata <= ~pm_rdata;
		if (rst || !pm_req)
		begin
			wait_q <= 4'h0;
			served_q <= 1'b0;
		end
		else if (!served_q && wait_q != delay)
			wait_q <= wait_q + 4'h1;
		else if (!served_q)
		begin
			pm_ack <= 1'b1;
			served_q <= 1'b1;
			if (pm_we)
				mem[pm_addr] <= pm_wdata;
			pm_rdata <= mem[pm_addr];
		end
	end
endmodule // nvac_pm_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the nv memory access controller
`default_nettype none
module tb_top
	import nvac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short write time keeps the run brief
	localparam int unsigned WC = 20;
	logic clk_sys, rst, pwr_on_rst, reg_we, reg_re, irq;
	logic [3:0] reg_addr, pm_delay;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] cfg_self_write_protect;
	logic cfg_code_protect, charge_pump_en, ext_prog_allow;
	logic pm_req, pm_we, pm_ack, ack_we;
	logic [14:0] pm_addr, ack_addr;
	logic [13:0] pm_wdata, pm_rdata, ack_data;
	int fails, num_checks, cyc, pump_cnt, ack_n;
	nvac_top #(.WRITE_CYCLES(WC)) u_dut (
		.clk_sys, .rst, .pwr_on_rst, .reg_addr, .reg_wdata, .reg_we,
		.reg_re, .reg_rdata, .cfg_self_write_protect, .cfg_code_protect,
		.pm_req, .pm_we, .pm_addr, .pm_wdata, .pm_ack, .pm_rdata,
		.charge_pump_en, .ext_prog_allow, .irq
	);
	nvac_pm_model u_pm (
		.clk_sys, .rst, .delay(pm_delay), .pm_req, .pm_we, .pm_addr,
		.pm_wdata, .pm_ack, .pm_rdata
	);
	initial
	begin
		clk_sys = 1'b0;
		forever
			#2 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	task automatic unlock();
		wr(NVAC_IDX_UNLOCK, NVAC_KEY1);
		wr(NVAC_IDX_UNLOCK, NVAC_KEY2);
	endtask
	// Polls until both triggers are back to zero
	task automatic wait_trig();
		logic [7:0] v;
		int n;
		n = 0;
		do
			begin
				rd(NVAC_IDX_CONTROL, v);
				n++;
			end
		while (v[1:0] !== 2'b00 && n < 200);
		chk(v[1:0], 2'b00);
	endtask
	task automatic regs4(input logic [7:0] ah, al, dh, dl);
		wr(NVAC_IDX_ADDR_HIGH, ah);
		wr(NVAC_IDX_ADDR_LOW, al);
		wr(NVAC_IDX_DATA_HIGH, dh);
		wr(NVAC_IDX_DATA_LOW, dl);
	endtask
	// Samples flash requests and counts write pump cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (charge_pump_en === 1'b1)
			pump_cnt++;
		if (pm_ack === 1'b1)
		begin
			ack_n++;
			ack_we = pm_we;
			ack_addr = pm_addr;
			ack_data = pm_wdata;
		end
		if (cyc == 20000)
		begin
			fails++;
			$display("CHECK FAILED at %0t: run hung", $time);
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 10; i++)
			if (i != 8)
				rdchk(4'(i), 8'h00);
		wr(NVAC_IDX_UNLOCK, NVAC_KEY1);
		rdchk(NVAC_IDX_UNLOCK, 8'h00);
		wr(NVAC_IDX_UNLOCK, 8'h00);
		chk(ext_prog_allow, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_ee();
		logic [7:0] d;
		for (int k = 0; k < 2; k++)
		begin
			d = k ? 8'hA5 : 8'h5A;
			regs4(8'h00, 8'hFF, 8'h00, d);
			unlock();
			pump_cnt = 0;
			wr(NVAC_IDX_CONTROL, 8'h06);
			wr(NVAC_IDX_CONTROL, 8'h04);
			rdchk(NVAC_IDX_CONTROL, 8'h06);
			wait_trig();
			chk(pump_cnt inside {[WC-1:WC+1]}, 1'b1);
			rdchk(NVAC_IDX_INT_STATUS, 8'h01);
			chk(irq, 1'b0);
			wr(NVAC_IDX_INT_MASK, 8'h01);
			#1 chk(irq, 1'b1);
			wr(NVAC_IDX_INT_STATUS, 8'h01);
			#1 chk(irq, 1'b0);
			wr(NVAC_IDX_INT_MASK, 8'h00);
			wr(NVAC_IDX_DATA_LOW, 8'h00);
			wr(NVAC_IDX_CONTROL, 8'h01);
			wait_trig();
			rdchk(NVAC_IDX_DATA_LOW, d);
		end
		pump_cnt = 0;
		wr(NVAC_IDX_CONTROL, 8'h06);
		rdchk(NVAC_IDX_CONTROL, 8'h04);
		unlock();
		wr(NVAC_IDX_CONTROL, 8'h02);
		rdchk(NVAC_IDX_CONTROL, 8'h00);
		chk(pump_cnt, 16'h0000);
		wr(NVAC_IDX_INT_STATUS, 8'h03);
		$display("test eeprom done");
	endtask
	task automatic t_pm();
		int n;
		pm_delay <= 4'h5;
		regs4(8'h12, 8'h34, 8'h2A, 8'hCD);
		unlock();
		n = ack_n;
		wr(NVAC_IDX_CONTROL, 8'h86);
		wait_trig();
		chk(16'(ack_n - n), 16'h0001);
		chk({ack_we, ack_addr}, {1'b1, 15'h1234});
		chk(ack_data, 14'h2ACD);
		wr(NVAC_IDX_INT_STATUS, 8'h01);
		pm_delay <= 4'h0;
		regs4(8'h12, 8'h34, 8'h00, 8'h00);
		wr(NVAC_IDX_CONTROL, 8'h81);
		wait_trig();
		chk({ack_we, ack_addr}, {1'b0, 15'h1234});
		rdchk(NVAC_IDX_DATA_HIGH, 8'h2A);
		rdchk(NVAC_IDX_DATA_LOW, 8'hCD);
		rdchk(NVAC_IDX_CONTROL, 8'h80);
		$display("test program memory done");
	endtask
	task automatic t_prot();
		int n;
		cfg_self_write_protect <= 2'b10;
		regs4(8'h01, 8'h00, 8'h15, 8'h55);
		unlock();
		n = ack_n;
		wr(NVAC_IDX_CONTROL, 8'h86);
		wait_trig();
		chk(16'(ack_n - n), 16'h0000);
		rdchk(NVAC_IDX_INT_STATUS, 8'h02);
		wr(NVAC_IDX_INT_STATUS, 8'h02);
		wr(NVAC_IDX_CONTROL, 8'h81);
		wait_trig();
		chk(16'(ack_n - n), 16'h0001);
		rdchk(NVAC_IDX_DATA_HIGH, 8'h3F);
		cfg_self_write_protect <= 2'b01;
		regs4(8'h08, 8'h00, 8'h00, 8'h00);
		unlock();
		n = ack_n;
		wr(NVAC_IDX_CONTROL, 8'h86);
		wait_trig();
		chk(16'(ack_n - n), 16'h0000);
		rdchk(NVAC_IDX_INT_STATUS, 8'h02);
		wr(NVAC_IDX_INT_STATUS, 8'h02);
		cfg_self_write_protect <= 2'b11;
		$display("test protection done");
	endtask
	task automatic t_code();
		cfg_code_protect <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 chk(ext_prog_allow, 1'b0);
		regs4(8'h00, 8'hFF, 8'h00, 8'h00);
		wr(NVAC_IDX_CONTROL, 8'h01);
		wait_trig();
		rdchk(NVAC_IDX_DATA_LOW, 8'hA5);
		cfg_code_protect <= 1'b0;
		$display("test code protect done");
	endtask
	task automatic t_abort();
		regs4(8'h00, 8'h10, 8'h00, 8'h77);
		unlock();
		wr(NVAC_IDX_CONTROL, 8'h86);
		repeat (4) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk(charge_pump_en, 1'b0);
		rdchk(NVAC_IDX_CONTROL, 8'h08);
		wr(NVAC_IDX_CONTROL, 8'h00);
		rdchk(NVAC_IDX_CONTROL, 8'h00);
		$display("test abort done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		pwr_on_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		pm_delay = 4'h2;
		cfg_self_write_protect = 2'b11;
		cfg_code_protect = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		pwr_on_rst <= 1'b0;
		t_reset();
		t_ee();
		t_pm();
		t_prot();
		t_code();
		t_abort();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
